//--- core/asp_pkg.sv
`default_nettype none
package asp_pkg;
  // Access control word layout, sent msb first
  localparam int ACW_BITS      = 8;
  localparam int ACW_START_POS = 7;
  localparam int ACW_RS_HI     = 6;
  localparam int ACW_RS_LO     = 4;
  localparam int ACW_RW_POS    = 3;
  localparam int ACW_MODE_POS  = 0;
  // Register select codes
  localparam logic [2:0] SEL_ACCESS = 3'h0;
  localparam logic [2:0] SEL_GSR1   = 3'h1;
  localparam logic [2:0] SEL_GSR2   = 3'h2;
  localparam logic [2:0] SEL_SFR    = 3'h3;
  localparam logic [2:0] SEL_RESULT = 3'h7;
  // Word lengths per register
  localparam int REG_BITS      = 8;
  localparam int RESULT_BITS   = 24;
  localparam int ONES_RESET    = 32;
  localparam int ONES_W        = 6;
  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  // Busy pulse on ready line when unread
  localparam int BUSY_NS       = 200;
  localparam int CLK_NS        = 25;
  localparam int BUSY_CYC      = (BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_W        = 8;
  typedef enum logic [1:0] {ASP_CMD, ASP_WR, ASP_RD} asp_phase_t;
endpackage
`default_nettype wire

//--- core/asp_serial_port.sv
// How it works
// R1 - Ready low while fresh result waits
// R2 - Full result read releases ready high
// R3 - Unread result: short high busy pulse
// R4 - Host must not read while ready high
// R5 - Raw mode: ready pin strobes data
// R6 - Reads shift out selected register
// R7 - Raw mode: modulator bit on output
// R8 - Input shift register loads chosen register
// R9 - Select bits pick write destination
// R10 - Continuous or burst serial clock works
// R11 - Chip select picks active clock edge
// R12 - Chip select tied low: clock idles high
// R13 - Access word starts with zero bit
// R14 - Direction bit, three select bits
// R15 - Clock level latched at select fall
// R16 - Thirty-two ones reset the interface
// R17 - Drive output only during reads, and at all times in raw mode
// R18 - Most significant bit first
`default_nettype none
module asp_serial_port
  import asp_pkg::*;
#(
  parameter int BUSY_CYCLES = BUSY_CYC
) (
  input  wire logic                   clock,
  input  wire logic                   reset,
  input  wire logic                   cs_n,
  input  wire logic                   sclk,
  input  wire logic                   sdi,
  input  wire logic                   mod_bit,
  input  wire logic                   mod_strobe,
  input  wire logic                   result_valid,
  input  wire logic [RESULT_BITS-1:0] result_word,
  output logic                        sdo,
  output logic                        sdo_oe_n,
  output logic                        ready_n,
  output logic [REG_BITS-1:0]         access_control_register,
  output logic [REG_BITS-1:0]         gsr1,
  output logic [REG_BITS-1:0]         gsr2,
  output logic [REG_BITS-1:0]         sfr,
  output logic [REG_BITS-1:0]         tfr1,
  output logic [REG_BITS-1:0]         tfr2,
  output logic [REG_BITS-1:0]         tfr3,
  output logic                        raw_bitstream_select
);
  // --------------------------------------------------------------------
  // Synchronisers
  // --------------------------------------------------------------------
  logic [4:0] pins_s;
  asp_sync #(.W(5)) u_sync (
    .clock    (clock),
    .async_in ({cs_n, sclk, sdi, mod_bit, mod_strobe}),
    .sync_out (pins_s)
  );
  logic cs_s, sclk_s, sdi_s, mod_s, mstb_s;
  assign {cs_s, sclk_s, sdi_s, mod_s, mstb_s} = pins_s;

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    logic                   cs_d;
    logic                   sclk_d;
    logic                   cpol;
    asp_phase_t             phase;
    logic [RESULT_BITS-1:0] sh;
    logic [4:0]             cnt;
    logic [4:0]             len;
    logic [2:0]             dst;
    logic [ONES_W-1:0]      ones;
    logic [0:7][7:0]        regs;
    logic                   fresh;
    logic                   busy_pend;
    logic [BUSY_W-1:0]      busy;
    logic                   sdo;
    logic                   oe_n;
    logic                   rdy_n;
  } asp_state_t;

  asp_state_t cur_ff, nxt_ff;

  function automatic logic [4:0] word_len(input logic [2:0] sel);
    word_len = (sel == SEL_RESULT) ? 5'(RESULT_BITS) : 5'(REG_BITS);
  endfunction

  logic sel_now, fall_cs, act_edge, drive_edge;
  assign sel_now = !cs_s;
  assign fall_cs = cur_ff.cs_d && !cs_s;
  // R11 - edge from polarity
  assign act_edge   = sel_now && !fall_cs &&
                      (cur_ff.cpol ? (!cur_ff.sclk_d && sclk_s) : (cur_ff.sclk_d && !sclk_s));
  assign drive_edge = sel_now && !fall_cs &&
                      (cur_ff.cpol ? (cur_ff.sclk_d && !sclk_s) : (!cur_ff.sclk_d && sclk_s));

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.cs_d   = cs_s;
    nxt_ff.sclk_d = sclk_s;
    // R15 - latch idle level
    if (fall_cs) begin
      nxt_ff.cpol = sclk_s;
    end
    // Result arrival and busy pulse
    if (result_valid) begin
      // R3 - busy pulse if unread
      if (cur_ff.fresh) begin
        nxt_ff.busy = BUSY_W'(BUSY_CYCLES);
      end
      nxt_ff.fresh = 1'b1;
    end else if (cur_ff.busy != '0) begin
      nxt_ff.busy = cur_ff.busy - 1'b1;
    end
    // R10 - each edge one bit
    if (act_edge) begin
      // R16 - count trailing ones
      nxt_ff.ones = sdi_s ? ((cur_ff.ones == ONES_W'(ONES_RESET - 1)) ? '0 : cur_ff.ones + 1'b1)
                          : '0;
      // R18 - msb first
      nxt_ff.sh  = {cur_ff.sh[RESULT_BITS-2:0], sdi_s};
      nxt_ff.cnt = cur_ff.cnt + 1'b1;
      unique case (cur_ff.phase)
        ASP_CMD: begin
          // R13 - wait for zero start
          if (cur_ff.cnt == '0 && sdi_s) begin
            nxt_ff.cnt = '0;
          end else if (cur_ff.cnt == 5'(ACW_BITS - 1)) begin
            nxt_ff.cnt = '0;
            nxt_ff.regs[SEL_ACCESS] = {cur_ff.sh[6:0], sdi_s};
            // R14 - direction and select
            nxt_ff.dst = cur_ff.sh[ACW_RS_HI-1:ACW_RS_LO-1];
            nxt_ff.len = word_len(cur_ff.sh[ACW_RS_HI-1:ACW_RS_LO-1]);
            if (cur_ff.sh[ACW_RW_POS-1]) begin
              nxt_ff.phase = ASP_RD;
            end else if (cur_ff.sh[ACW_RS_HI-1:ACW_RS_LO-1] != SEL_ACCESS) begin
              nxt_ff.phase = ASP_WR;
            end
          end
        end
        ASP_WR: begin
          if (cur_ff.cnt == cur_ff.len - 1'b1) begin
            // R8 - transfer to register
            // R9 - destination from select
            if (cur_ff.dst != SEL_RESULT) begin
              nxt_ff.regs[cur_ff.dst] = {cur_ff.sh[6:0], sdi_s};
            end
            nxt_ff.cnt   = '0;
            nxt_ff.phase = ASP_CMD;
          end
        end
        ASP_RD: begin
          if (cur_ff.cnt == cur_ff.len - 1'b1) begin
            // R2 - read done releases ready
            if (cur_ff.dst == SEL_RESULT) begin
              nxt_ff.fresh = result_valid;
            end
            nxt_ff.cnt   = '0;
            nxt_ff.phase = ASP_CMD;
          end
        end
        default: nxt_ff.phase = ASP_CMD;
      endcase
      if (sdi_s && cur_ff.ones == ONES_W'(ONES_RESET - 1)) begin
        nxt_ff.phase = ASP_CMD;
        nxt_ff.cnt   = '0;
      end
    end
    // R6 - shift out selected register
    if (cur_ff.phase == ASP_RD && drive_edge) begin
      if (cur_ff.dst == SEL_RESULT) begin
        nxt_ff.sdo = result_word[5'(RESULT_BITS - 1) - cur_ff.cnt];
      end else begin
        nxt_ff.sdo = cur_ff.regs[cur_ff.dst][3'(7 - cur_ff.cnt)];
      end
    end
    // R17 - drive only during reads
    nxt_ff.oe_n = !(sel_now && cur_ff.phase == ASP_RD && !cur_ff.regs[SEL_ACCESS][ACW_MODE_POS]);
    // R1 - low while result waits
    nxt_ff.rdy_n = !(cur_ff.fresh && cur_ff.busy == '0);
    if (cur_ff.regs[SEL_ACCESS][ACW_MODE_POS]) begin
      // R7 - raw modulator stream
      nxt_ff.sdo   = mod_s;
      nxt_ff.oe_n  = 1'b0;
      // R5 - ready becomes strobe
      nxt_ff.rdy_n = mstb_s;
    end
    if (reset) begin
      nxt_ff.phase = ASP_CMD;
      nxt_ff.cnt   = '0;
      nxt_ff.ones  = '0;
      // R12 - no select fall: idle high
      nxt_ff.cpol  = 1'b1;
      nxt_ff.fresh = 1'b0;
      nxt_ff.busy  = '0;
      nxt_ff.sdo   = 1'b1;
      nxt_ff.oe_n  = 1'b1;
      nxt_ff.rdy_n = 1'b1;
      nxt_ff.sh    = '0;
      nxt_ff.len   = 5'(REG_BITS);
      nxt_ff.dst   = SEL_ACCESS;
      for (int i = 0; i < 8; i++) begin
        nxt_ff.regs[i] = REG_RESET;
      end
    end
  end

  always_ff @(posedge clock) begin
    cur_ff <= nxt_ff;
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign sdo                     = cur_ff.sdo;
  assign sdo_oe_n                = cur_ff.oe_n;
  assign ready_n                 = cur_ff.rdy_n;
  assign access_control_register = cur_ff.regs[SEL_ACCESS];
  assign gsr1                    = cur_ff.regs[SEL_GSR1];
  assign gsr2                    = cur_ff.regs[SEL_GSR2];
  assign sfr                     = cur_ff.regs[SEL_SFR];
  assign tfr1                    = cur_ff.regs[4];
  assign tfr2                    = cur_ff.regs[5];
  assign tfr3                    = cur_ff.regs[6];
  assign raw_bitstream_select    = cur_ff.regs[SEL_ACCESS][ACW_MODE_POS];
endmodule
`default_nettype wire

//--- core/asp_sync.sv
`default_nettype none
module asp_sync
  import asp_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic         clock,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  always_ff @(posedge clock) begin
    meta_ff <= async_in;
    sync_ff <= meta_ff;
  end
  assign sync_out = sync_ff;
endmodule
`default_nettype wire

//--- test/asp_host.sv
`default_nettype none
module asp_host (
  input  wire logic clock,
  input  wire logic sdo,
  output logic      cs_n,
  output logic      sclk,
  output logic      sdi
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------
  // Framed transfer
  // ----------------
  logic tied;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    sdi  = 1'b1;
    tied = 1'b0;
  end
  // Select held low across frames, or released again
  task automatic hold_select(input logic on);
    tied = on;
    cs_n <= 1'b1;
    repeat (4) @(posedge clock);
  endtask
  task automatic xfer(input logic idle, input logic [31:0] tx, input int n,
                      output logic [31:0] rx);
    logic lvl;
    rx = 32'h0;
    lvl = idle | tied;
    sclk <= lvl;
    repeat (2) @(posedge clock);
    cs_n <= 1'b0;
    repeat (4) @(posedge clock);
    for (int i = n - 1; i >= 0; i--) begin
      sclk <= ~lvl;
      sdi  <= tx[i];
      repeat (4) @(posedge clock);
      sclk <= lvl;
      #1 rx = {rx[30:0], sdo};
      repeat (4 + $urandom_range(0, 2)) @(posedge clock);
    end
    sdi  <= 1'b1;
    cs_n <= ~tied;
    repeat (8) @(posedge clock);
  endtask
endmodule
`default_nettype wire

//--- test/asp_monitor.sv
`default_nettype none
module asp_monitor
  import asp_pkg::*;
#(parameter int BUSY_CYCLES = BUSY_CYC) (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       cs_n,
  input wire logic       mod_bit,
  input wire logic       mod_strobe,
  input wire logic       result_valid,
  input wire logic       sdo,
  input wire logic       sdo_oe_n,
  input wire logic       ready_n,
  input wire logic [7:0] access_control_register,
  input wire logic [7:0] gsr1,
  input wire logic [7:0] gsr2,
  input wire logic [7:0] sfr,
  input wire logic [7:0] tfr1,
  input wire logic [7:0] tfr2,
  input wire logic [7:0] tfr3,
  input wire logic       raw_bitstream_select
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BMAX = BUSY_CYCLES + 8;
  wire logic        raw  = raw_bitstream_select;
  wire logic [47:0] regs = {gsr1, gsr2, sfr, tfr1, tfr2, tfr3};
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  // ----------------
  // Port checks
  // ----------------
  rst_idle_a: assert property ($fell(reset) |-> ready_n && sdo_oe_n && regs == 48'h0)
    else $error("not idle after reset");
  fresh_ready_a: assert property (result_valid && !raw |-> ##[1:BMAX] !ready_n)
    else $error("ready late");
  drive_read_a: assert property ((cs_n && !raw) [*5] |-> sdo_oe_n)
    else $error("output driven while idle");
  ready_strobe_a: assert property ((raw && $stable(mod_strobe)) [*5] |-> ready_n == mod_strobe)
    else $error("strobe not copied");
  raw_out_a: assert property ((raw && $stable(mod_bit)) [*5] |-> sdo == mod_bit)
    else $error("raw bit not on output");
  regs_hold_a: assert property (cs_n [*5] |=> $stable(regs))
    else $error("register changed while idle");
  one_dest_a: assert property ($onehot0({$changed(gsr1), $changed(gsr2), $changed(sfr),
    $changed(tfr1), $changed(tfr2), $changed(tfr3)})) else $error("two registers written");
  start_zero_a: assert property (!access_control_register[ACW_START_POS])
    else $error("start bit stored as one");
  cover property (!sdo_oe_n);
  cover property (raw && !mod_strobe);
  cover property (result_valid ##[1:BMAX] !ready_n);
endmodule
`default_nettype wire

//--- test/tb.sv
`default_nettype none
module tb
  import asp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock, reset, cs_n, sclk, sdi, mod_bit, mod_strobe, result_valid;
  logic        sdo, sdo_oe_n, ready_n, raw_bitstream_select;
  logic [23:0] result_word;
  logic [7:0]  access_control_register, gsr1, gsr2, sfr, tfr1, tfr2, tfr3;
  logic [7:0]  exp_q [0:7];
  logic [31:0] rx;
  logic [2:0]  sel_r;
  int          miscompares, tests_run, seed;
  wire logic [55:0] all_q = {tfr3, tfr2, tfr1, sfr, gsr2, gsr1, access_control_register};
  asp_host i_host (.clock, .sdo, .cs_n, .sclk, .sdi);
  asp_serial_port #(.BUSY_CYCLES(8)) i_dut (.clock, .reset, .cs_n, .sclk, .sdi, .mod_bit,
    .mod_strobe, .result_valid, .result_word, .sdo, .sdo_oe_n, .ready_n,
    .access_control_register, .gsr1, .gsr2, .sfr, .tfr1, .tfr2, .tfr3, .raw_bitstream_select);
  // ----------------
  // Helpers
  // ----------------
  function automatic logic [7:0] acw(input logic [2:0] s, input logic rd, input logic raw);
    return {1'b0, s, rd, 2'b00, raw};
  endfunction
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    if (miscompares == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_rdy(input logic v);
    int k;
    for (k = 0; k < 400 && ready_n !== v; k++) @(posedge clock);
    chk("ready wait", k < 400, 1'b1);
    if (k == 400) test_done();
  endtask
  task automatic chk_regs();
    for (int i = 0; i < 7; i++) chk("register", all_q[8*i +: 8], exp_q[i]);
  endtask
  task automatic acc(input logic [2:0] s, input logic rd, input logic [7:0] v, input int lead);
    int n;
    // Result word takes 24 data bits even when the write is ignored
    n = (s == SEL_RESULT) ? 32 : 16;
    i_host.xfer(1'($urandom), (n == 32) ? {acw(s, rd, 1'b0), v, 16'hffff}
                : {16'hffff, acw(s, rd, 1'b0), rd ? 8'hff : v},
                n + ((n == 16) ? lead : 0), rx);
    exp_q[0] = acw(s, rd, 1'b0);
    if (rd) chk("read", rx[7:0], exp_q[s]);
    else if (s != SEL_RESULT) exp_q[s] = v;
    chk_regs();
  endtask
  task automatic pulse();
    result_word  <= 24'($urandom);
    result_valid <= 1'b1;
    @(posedge clock);
    result_valid <= 1'b0;
  endtask
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    {reset, mod_bit, mod_strobe, result_valid, result_word} = {1'b1, 27'h0};
    foreach (exp_q[i]) exp_q[i] = REG_RESET;
    seed = $urandom(73124);
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    repeat (4) @(posedge clock);
    chk_regs();
    chk("idle", {ready_n, sdo_oe_n}, 2'b11);
    for (int i = 0; i < 14; i++) begin
      acc(3'(1 + i % 7), 1'b0, 8'($urandom), i == 3 ? 4 : 0);
      acc(3'($urandom_range(0, 6)), 1'b1, 8'h00, 0);
    end
    i_host.hold_select(1'b1);
    repeat (3) begin
      sel_r = 3'(1 + $urandom_range(0, 5));
      acc(sel_r, 1'b0, 8'($urandom), 0);
      acc(sel_r, 1'b1, 8'h00, 0);
    end
    i_host.hold_select(1'b0);
    i_host.xfer(1'b1, 32'hffffffff, 32, rx);
    chk_regs();
    pulse();
    wait_rdy(1'b0);
    pulse();
    wait_rdy(1'b1);
    wait_rdy(1'b0);
    i_host.xfer(1'b1, {acw(SEL_RESULT, 1'b1, 1'b0), 24'hffffff}, 32, rx);
    chk("result", rx[23:0], result_word);
    wait_rdy(1'b1);
    i_host.xfer(1'b1, {24'h0, acw(3'h0, 1'b0, 1'b1)}, 8, rx);
    repeat (6) begin
      mod_bit    <= 1'($urandom);
      mod_strobe <= 1'($urandom);
      repeat (6) @(posedge clock);
      chk("raw", {raw_bitstream_select, ready_n, sdo}, {1'b1, mod_strobe, mod_bit});
    end
    i_host.xfer(1'b1, 32'h0, 8, rx);
    chk("raw off", raw_bitstream_select, 1'b0);
    exp_q[0] = 8'h00;
    chk_regs();
    test_done();
  end
endmodule
bind asp_serial_port asp_monitor #(.BUSY_CYCLES(BUSY_CYCLES)) i_mon (.clock, .reset, .cs_n,
  .mod_bit, .mod_strobe, .result_valid, .sdo, .sdo_oe_n, .ready_n, .access_control_register,
  .gsr1, .gsr2, .sfr, .tfr1, .tfr2, .tfr3, .raw_bitstream_select);
`default_nettype wire
